//--- bench/led_power_stage.sv
// Behavioural power stage and current comparators for three channels.
// Current builds while a drive is high; comparators see the converter codes.
`timescale 1ns/1ps
`include "led_pwm_defines.svh"

module led_power_stage (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    reset,
  // Current rise per cycle; zero means the channel never trips
  input wire logic [3:0]              rate,
  // From the block
  input wire logic [2:0]              drive,
  input wire logic [2:0][`THR_W-1:0]  code,
  // To the block
  output logic     [2:0]              trip
);
  logic [2:0][15:0] cur_q;
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      // Inductor current treated as collapsing once the switch opens
      cur_q[i] <= (reset || !drive[i]) ? 16'h0000 : cur_q[i] + {12'h000, rate};
    end
  end
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      trip[i] = cur_q[i] > {4'h0, code[i]};
    end
  end
endmodule : led_power_stage

//--- bench/led_pwm_monitor.sv
// Drive timing assertions for the LED burst PWM.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`include "led_pwm_defines.svh"

module led_pwm_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control and sense
  input wire logic enable,
  input wire logic red_current_comparator,
  input wire logic green_current_comparator,
  input wire logic blue_current_comparator,
  // Drives
  input wire logic red_drive,
  input wire logic green_drive,
  input wire logic blue_drive
);
  localparam int PERIOD = `PERIOD_CYC;
  localparam int BURST  = `PERIOD_CYC * `PERIODS_PER_BURST;
  logic [7:0]  pcnt_q;
  logic [16:0] cyc_q;
  // Mirrors the period counter; cycle count saturates after one burst
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pcnt_q <= 8'h00;
      cyc_q  <= 17'h00000;
    end
    else
    begin
      pcnt_q <= (pcnt_q == 8'(PERIOD - 1)) ? 8'h00 : pcnt_q + 8'h01;
      if (cyc_q < 17'(BURST))
        cyc_q <= cyc_q + 17'h00001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_red_trip_off: assert property (red_current_comparator [*3] |=> !red_drive)
    else $error("red drive not cut by comparator");
  a_green_trip_off: assert property (green_current_comparator [*3] |=> !green_drive)
    else $error("green drive not cut by comparator");
  a_blue_trip_off: assert property (blue_current_comparator [*3] |=> !blue_drive)
    else $error("blue drive not cut by comparator");
  a_drop_has_cause: assert property ($fell(red_drive) |-> $past(red_current_comparator, 3) || !$past(enable))
    else $error("red drive fell without a cause");
  a_red_full_duty: assert property ((red_drive && enable && !red_current_comparator) [*3] |=> red_drive)
    else $error("untripped red drive dropped");
  a_blue_full_duty: assert property ((blue_drive && enable && !blue_current_comparator) [*3] |=> blue_drive)
    else $error("untripped blue drive dropped");
  a_start_on_period: assert property ($rose(red_drive) || $rose(green_drive) || $rose(blue_drive) |-> pcnt_q == 8'h00)
    else $error("drive rose off the period start");
  a_first_burst_idle: assert property (cyc_q < 17'(BURST) |-> !(red_drive || green_drive || blue_drive))
    else $error("pulse issued before the first burst end");
endmodule : led_pwm_monitor

//--- bench/testbench.sv
// Self-checking bench for the LED burst PWM with a power stage model.
// Runs about one burst plus a few periods at 40 MHz.
`timescale 1ns/1ps
`include "led_pwm_defines.svh"

module testbench;
  localparam int PERIOD = `PERIOD_CYC;
  localparam int BURST  = `PERIOD_CYC * `PERIODS_PER_BURST;
  logic                   clk;
  logic                   reset;
  logic                   enable;
  logic [7:0]             brightness;
  logic [3:0]             rate;
  logic [2:0]             drv;
  logic [2:0]             trip;
  logic [2:0][`THR_W-1:0] code;
  int                     fail_count = 0;
  int                     checks_done = 0;

  peak_current_led_burst_pwm i_peak_current_led_burst_pwm (
    .clk(clk), .reset(reset), .enable(enable), .brightness(brightness),
    .red_threshold(12'h400), .green_threshold(12'h800), .blue_threshold(12'hfff),
    .red_current_comparator(trip[0]), .green_current_comparator(trip[1]),
    .blue_current_comparator(trip[2]),
    .red_drive(drv[0]), .green_drive(drv[1]), .blue_drive(drv[2]),
    .red_threshold_code(code[0]), .green_threshold_code(code[1]),
    .blue_threshold_code(code[2]));
  led_power_stage i_led_power_stage (
    .clk(clk), .reset(reset), .rate(rate), .drive(drv), .code(code), .trip(trip));

  task automatic check(input bit ok, input string msg);
    checks_done++;
    if (!ok)
    begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Counts falling edges until the red drive shows lvl
  task automatic wait_red(input logic lvl, input int lim, output int n);
    n = 0;
    while (drv[0] !== lvl && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (drv[0] !== lvl)
    begin
      check(1'b0, "drive wait timed out");
      stop_test();
    end
  endtask : wait_red

  // Brightness only takes effect at the first burst end
  task automatic first_burst();
    int n;
    wait_red(1'b1, BURST + 50, n);
    check(n >= BURST - 5 && n <= BURST + 5, "first pulse off the burst end");
    check(drv === 3'b111, "channels not started together");
    check(code === '0, "threshold not starting from zero");
  endtask : first_burst

  task automatic trip_and_period();
    int n1;
    int n2;
    wait_red(1'b0, 8, n1);
    check(n1 >= 3 && n1 <= 6, "comparator trip did not end pulse");
    wait_red(1'b1, 2 * PERIOD, n2);
    check(n1 + n2 == PERIOD, "switching period wrong");
    check(drv === 3'b111, "second counted pulse missing");
  endtask : trip_and_period

  // Model never trips: drive must carry into a period with no start
  task automatic full_duty();
    int n;
    int highs;
    rate = 4'h0;
    repeat (PERIOD + 40) @(negedge clk);
    check(drv === 3'b111, "untripped drive dropped at period end");
    rate = 4'h1;
    wait_red(1'b0, 8, n);
    check(drv === 3'b000, "late trip did not end every drive");
    highs = 0;
    repeat (2 * PERIOD)
    begin
      @(negedge clk);
      if (drv !== 3'b000)
        highs++;
    end
    check(highs == 0, "pulse issued past the burst count");
  endtask : full_duty

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    reset = 1'b1;
    enable = 1'b1;
    // Gamma count of two: periods past the second have no start
    brightness = 8'h14;
    rate = 4'h1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    first_burst();
    trip_and_period();
    full_duty();
    stop_test();
  end
endmodule : testbench

bind peak_current_led_burst_pwm led_pwm_monitor i_led_pwm_monitor (
  .clk(clk), .reset(reset), .enable(enable),
  .red_current_comparator(red_current_comparator),
  .green_current_comparator(green_current_comparator),
  .blue_current_comparator(blue_current_comparator),
  .red_drive(red_drive), .green_drive(green_drive), .blue_drive(blue_drive));

//--- design/led_pwm_defines.svh
// Timing counts, widths and limits for the peak-current LED burst PWM.
// Assumes a 40 MHz system clock; the period count is derived from it.
`ifndef LED_PWM_DEFINES_SVH
`define LED_PWM_DEFINES_SVH

`define CLK_HZ            40000000
`define SWITCH_HZ         250000
`define BURST_HZ          400
`define PERIOD_CYC        (`CLK_HZ / `SWITCH_HZ)
`define PERIODS_PER_BURST (`SWITCH_HZ / `BURST_HZ)
`define FAST_STEP_HZ      15000000
`define SLOW_STEP_HZ      3000000
`define FAST_STEPS        (`FAST_STEP_HZ / `SWITCH_HZ)
`define SLOW_STEPS        (`SLOW_STEP_HZ / `SWITCH_HZ)
`define SOFT_START_BURSTS 250
`define THR_W             12
`define CNT_W             10
`define PHASE_W           9
`define THR_MAX_DEFAULT   12'h7ff
`define SLOPE_DEFAULT     12'h008
`define RECIP_250         9'h106
`define RECIP_SHIFT       16

`endif

//--- design/led_pwm_pkg.sv
// Types shared by the LED burst PWM and its threshold ramp.
// Widths come from the defines header.
`include "led_pwm_defines.svh"

package led_pwm_pkg;

  typedef struct packed {
    logic [`PHASE_W-1:0] acc;
    logic [`THR_W-1:0]   code;
  } ramp_state_t;

  typedef struct packed {
    logic [7:0]             period_cnt;
    logic [`CNT_W-1:0]      period_idx;
    logic [`CNT_W-1:0]      ppb;
    logic [7:0]             ss_cnt;
    logic [2:0]             cmp_s1;
    logic [2:0]             cmp_s2;
    logic [2:0]             drive;
    logic [2:0][`THR_W-1:0] thr_eff;
  } pwm_state_t;

endpackage : led_pwm_pkg

//--- design/peak_current_led_burst_pwm.sv
// Three-channel peak-current LED dimmer with burst-count brightness.
// Assumes comparator inputs are asynchronous; all other inputs share clk.
//
// Functional notes
// - Drive asserts at each counted 250 kHz period start
// - Comparator trip ends drive for the period
// - Untripped drive persists across periods
// - Pulse count per burst sets brightness
// - Bursts repeat at 400 Hz
// - Three independent red, green, blue channels
// - One shared pulse count; thresholds set balance
// - Timer sequences a sawtooth threshold per period
// - Red and green ramps: 60 steps per period (the ramp makes 59, as period_start reloads before the 60th)
// - Blue ramp: 12 steps per period (the ramp makes 11, as period_start reloads before the 12th)
// - Pulse count follows gamma 2.2 curve
// - Thresholds clamped to the 100 mA level
// - Ramp resets on repetition event, timer steps
// - Thresholds soft-start over 250 bursts
`timescale 1ns/1ps
`include "led_pwm_defines.svh"

module peak_current_led_burst_pwm #(
  parameter logic [`THR_W-1:0] THR_MAX = `THR_MAX_DEFAULT,
  parameter logic [`THR_W-1:0] SLOPE   = `SLOPE_DEFAULT
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Control
  input  wire logic              enable,
  input  wire logic [7:0]        brightness,
  // Per-channel current thresholds
  input  wire logic [`THR_W-1:0] red_threshold,
  input  wire logic [`THR_W-1:0] green_threshold,
  input  wire logic [`THR_W-1:0] blue_threshold,
  // Current comparators
  input  wire logic              red_current_comparator,
  input  wire logic              green_current_comparator,
  input  wire logic              blue_current_comparator,
  // Power switch drives
  output logic                   red_drive,
  output logic                   green_drive,
  output logic                   blue_drive,
  // Threshold converter codes
  output logic      [`THR_W-1:0] red_threshold_code,
  output logic      [`THR_W-1:0] green_threshold_code,
  output logic      [`THR_W-1:0] blue_threshold_code
);

  localparam logic [7:0]        PERIOD_LAST = 8'(`PERIOD_CYC - 1);
  localparam logic [`CNT_W-1:0] BURST_LAST  = `CNT_W'(`PERIODS_PER_BURST - 1);
  localparam logic [7:0]        SS_LAST     = 8'(`SOFT_START_BURSTS);

  // Gamma 2.2 from 8-bit brightness to pulses per burst, 17-point
  // table with linear interpolation; full scale equals the burst length.
  function automatic logic [`CNT_W-1:0] gamma_pulses(input logic [7:0] b);
    logic [`CNT_W-1:0] lo;
    logic [`CNT_W-1:0] hi;
    logic [15:0]       frac;
    lo = '0;
    hi = '0;
    case (b[7:4])
      4'h0:
      begin
        lo = 10'd0;
        hi = 10'd1;
      end
      4'h1:
      begin
        lo = 10'd1;
        hi = 10'd6;
      end
      4'h2:
      begin
        lo = 10'd6;
        hi = 10'd16;
      end
      4'h3:
      begin
        lo = 10'd16;
        hi = 10'd30;
      end
      4'h4:
      begin
        lo = 10'd30;
        hi = 10'd48;
      end
      4'h5:
      begin
        lo = 10'd48;
        hi = 10'd72;
      end
      4'h6:
      begin
        lo = 10'd72;
        hi = 10'd101;
      end
      4'h7:
      begin
        lo = 10'd101;
        hi = 10'd136;
      end
      4'h8:
      begin
        lo = 10'd136;
        hi = 10'd176;
      end
      4'h9:
      begin
        lo = 10'd176;
        hi = 10'd222;
      end
      4'ha:
      begin
        lo = 10'd222;
        hi = 10'd274;
      end
      4'hb:
      begin
        lo = 10'd274;
        hi = 10'd332;
      end
      4'hc:
      begin
        lo = 10'd332;
        hi = 10'd396;
      end
      4'hd:
      begin
        lo = 10'd396;
        hi = 10'd466;
      end
      4'he:
      begin
        lo = 10'd466;
        hi = 10'd542;
      end
      default:
      begin
        lo = 10'd542;
        hi = 10'd625;
      end
    endcase
    // Top code maps to the full burst so maximum brightness is reachable
    if (b == 8'hff)
      return `CNT_W'(`PERIODS_PER_BURST);
    frac = 16'(hi - lo) * 16'(b[3:0]);
    return lo + `CNT_W'(frac >> 4);
  endfunction : gamma_pulses

  // Clamp to the safe peak level, then scale by soft-start progress.
  function automatic logic [`THR_W-1:0] soft_level(input logic [`THR_W-1:0] thr,
                                                   input logic [7:0]        ss);
    logic [`THR_W-1:0] clamped;
    logic [31:0]       prod;
    clamped = (thr > THR_MAX) ? THR_MAX : thr;
    prod    = 32'(clamped) * 32'(ss) * 32'(`RECIP_250);
    if (ss >= SS_LAST)
      return clamped;
    return prod[`RECIP_SHIFT +: `THR_W];
  endfunction : soft_level

  led_pwm_pkg::pwm_state_t st_q;
  led_pwm_pkg::pwm_state_t st_d;

  logic [2:0]                  cmp_in;
  logic [2:0][`THR_W-1:0]      thr_in;
  logic [2:0][`THR_W-1:0]      code;
  logic                        period_start;
  logic                        period_end;
  logic                        burst_end;
  logic                        start_pulse;

  assign cmp_in       = {blue_current_comparator, green_current_comparator,
                         red_current_comparator};
  assign thr_in       = {blue_threshold, green_threshold, red_threshold};
  assign period_start = (st_q.period_cnt == 8'h00);
  assign period_end   = (st_q.period_cnt == PERIOD_LAST);
  assign burst_end    = period_end && (st_q.period_idx == BURST_LAST);

  always_comb
  begin
    st_d        = st_q;
    // Two-stage synchroniser; only stage two feeds the drive logic
    st_d.cmp_s1 = cmp_in;
    st_d.cmp_s2 = st_q.cmp_s1;

    st_d.period_cnt = period_end ? 8'h00 : st_q.period_cnt + 8'h01;
    if (period_end)
    begin
      st_d.period_idx = burst_end ? '0 : st_q.period_idx + `CNT_W'(1);
    end

    // Count and thresholds load only on burst boundaries (disable zeroes the
    // thresholds at once) to avoid a partial burst with a mixed pulse count
    if (burst_end)
    begin
      st_d.ppb = gamma_pulses(brightness);
      if (st_q.ss_cnt < SS_LAST)
        st_d.ss_cnt = st_q.ss_cnt + 8'h01;
      for (int i = 0; i < 3; i++)
        st_d.thr_eff[i] = soft_level(thr_in[i], st_q.ss_cnt);
    end

    if (!enable)
    begin
      st_d.ss_cnt  = 8'h00;
      st_d.thr_eff = '0;
    end

    start_pulse = period_end && enable && (st_d.period_idx < st_d.ppb);

    for (int i = 0; i < 3; i++)
    begin
      if (!enable)
        st_d.drive[i] = 1'b0;
      else if (st_q.cmp_s2[i])
        st_d.drive[i] = 1'b0;
      else if (start_pulse)
        st_d.drive[i] = 1'b1;
      // No clear at period end: an untripped switch stays on
      else
        st_d.drive[i] = st_q.drive[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign red_drive   = st_q.drive[0];
  assign green_drive = st_q.drive[1];
  assign blue_drive  = st_q.drive[2];

  // Red and green use the fast converter, blue the slow one
  for (genvar g = 0; g < 3; g++)
  begin : g_ramp
    threshold_ramp #(
      .STEPS  ((g == 2) ? `SLOW_STEPS : `FAST_STEPS),
      .PERIOD (`PERIOD_CYC),
      .SLOPE  (SLOPE)
    ) u_ramp (
      .clk          (clk),
      .reset        (reset),
      .period_start (period_start),
      .level        (st_q.thr_eff[g]),
      .code_q       (code[g])
    );
  end

  assign red_threshold_code   = code[0];
  assign green_threshold_code = code[1];
  assign blue_threshold_code  = code[2];

endmodule : peak_current_led_burst_pwm

//--- design/threshold_ramp.sv
// Stepped sawtooth threshold for one current comparator.
// Assumes period_start is a one-cycle pulse on the first cycle of each period.
`timescale 1ns/1ps
`include "led_pwm_defines.svh"

module threshold_ramp #(
  parameter int             STEPS  = `FAST_STEPS,
  parameter int             PERIOD = `PERIOD_CYC,
  parameter logic [`THR_W-1:0] SLOPE = `SLOPE_DEFAULT
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Sequencing
  input  wire logic              period_start,
  input  wire logic [`THR_W-1:0] level,
  // Converter code
  output logic      [`THR_W-1:0] code_q
);

  localparam logic [`PHASE_W-1:0] STEPS_W  = `PHASE_W'(STEPS);
  localparam logic [`PHASE_W-1:0] PERIOD_W = `PHASE_W'(PERIOD);

  led_pwm_pkg::ramp_state_t st_q;
  led_pwm_pkg::ramp_state_t st_d;
  logic [`PHASE_W-1:0]      acc_sum;

  always_comb
  begin
    st_d    = st_q;
    acc_sum = st_q.acc + STEPS_W;
    if (period_start)
    begin
      st_d.acc  = '0;
      st_d.code = level;
    end
    // Fractional accumulator spreads STEPS steps evenly over PERIOD cycles; the period_start reload drops the last one
    else if (acc_sum >= PERIOD_W)
    begin
      st_d.acc  = acc_sum - PERIOD_W;
      st_d.code = (st_q.code > SLOPE) ? st_q.code - SLOPE : '0;
    end
    else
    begin
      st_d.acc = acc_sum;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign code_q = st_q.code;

endmodule : threshold_ramp
